// ==== pkg/gml_pkg.sv ====
package gml_pkg;

    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam logic [15:0] GML_OFS_STATUS = 16'h0004;
    localparam logic [15:0] GML_OFS_ERROR = 16'h0008;
    localparam logic [15:0] GML_OFS_IRQ_EN = 16'h000C;
    localparam logic [15:0] GML_OFS_TBL_UPD = 16'h0100;
    localparam logic [15:0] GML_OFS_ADDR_DATA = 16'h0104;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int GML_IDX_MSB = 31;
    localparam int GML_IDX_LSB = 16;
    localparam int GML_VAL_MSB = 15;
    localparam int GML_VAL_LSB = 0;
    localparam int GML_UPD_SWAP = 0;
    localparam int GML_ST_START = 0;
    localparam int GML_ST_DONE = 1;
    localparam int GML_ST_SERR = 16;
    localparam int GML_ER_LE_EARLY = 0;
    localparam int GML_ER_LE_LATE = 1;
    localparam int GML_ER_FS_EARLY = 2;
    localparam int GML_ER_FS_LATE = 3;

    // Parallel event vector bit order
    localparam int GML_PEV_W = 9;
    localparam int GML_PEV_START = 0;
    localparam int GML_PEV_DONE = 1;
    localparam int GML_PEV_SERR = 4;
    localparam int GML_PEV_LE_EARLY = 5;
    localparam int GML_PEV_LE_LATE = 6;
    localparam int GML_PEV_FS_EARLY = 7;
    localparam int GML_PEV_FS_LATE = 8;

    // ---------------------------------------------------------------
    // Table windows and memory shape
    // ---------------------------------------------------------------
    localparam int GML_WIN_8 = 32'h0000_0100;
    localparam int GML_WIN_10 = 32'h0000_0400;
    localparam int GML_WIN_12 = 32'h0000_1000;
    localparam int GML_WIN_INTERP = 32'h0000_0400;
    localparam int GML_TBL_AW = 14;
    localparam int GML_TBL_DW = 16;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [31:0] GML_RST_REG = 32'h0000_0000;
    localparam logic GML_RST_BANK = 1'b0;

endpackage : gml_pkg

// ==== rtl/gml_table_mem.sv ====
`timescale 1ns/1ps
module gml_table_mem
    import gml_pkg::*;
#(
    parameter int AW = GML_TBL_AW + 1,
    parameter int DW = GML_TBL_DW
) (
    input wire logic mclk, // Core clock
    input wire logic resetn, // Async reset, active low
    input wire logic we, // Write strobe
    input wire logic [AW-1:0] waddr, // Write address
    input wire logic [DW-1:0] wdata, // Write data
    input wire logic [AW-1:0] raddr, // Read address
    output logic [DW-1:0] rdata_q // Registered read data
);

    logic [DW-1:0] mem [0:(2**AW)-1];
    logic [DW-1:0] rdata_d;

    // Storage array, written on strobe
    always_ff @(posedge mclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Read data next value
    always_comb begin
        rdata_d = mem[raddr];
    end

    // Read data register
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

endmodule : gml_table_mem

// ==== rtl/gml_lut_irq.sv ====
`timescale 1ns/1ps
// Function
// - Host writes store values into table
// - Index comes from bits 31 to 16
// - Value comes from bits 15 to 0
// - Table windows sized by input width, or 0x400 with INTERP
// - One, two or three tables built
// - Framing and frame events always detected
// - Interrupt output only with register bus
// - Level interrupt when flag and enable set
// - Flags held until host writes one
// - Optional parallel event vector output
// - Vector bits follow live event only
// - Fixed bit order of event vector
// - Interrupt is OR of masked flags
// - Double buffer writes inactive, bit swaps
module gml_lut_irq
    import gml_pkg::*;
#(
    parameter int IN_WIDTH = 8,
    parameter int NUM_TABLES = 3,
    parameter bit INTERP = 1'b0,
    parameter bit HAS_BUS = 1'b1,
    parameter bit EVENT_PORT = 1'b0,
    parameter bit DOUBLE_BUF = 1'b0
) (
    input wire logic mclk, // Core clock, 100 MHz
    input wire logic resetn, // Async reset, active low
    input wire logic reg_wr, // Register write strobe
    input wire logic reg_rd, // Register read strobe
    input wire logic [15:0] reg_addr, // Register byte offset
    input wire logic [31:0] reg_wdata, // Register write data
    output logic [31:0] reg_rdata, // Register read data
    output logic reg_rvalid, // Read data valid pulse
    input wire logic frame_start, // Frame processing started
    input wire logic frame_done, // Frame processing complete
    input wire logic line_end_early, // Line ended early
    input wire logic line_end_late, // Line ended late
    input wire logic frame_start_early, // Frame start early
    input wire logic frame_start_late, // Frame start late
    input wire logic [GML_TBL_AW-1:0] lut_rd_addr, // Datapath table address
    output logic [GML_TBL_DW-1:0] lut_rd_data, // Datapath table data
    output logic active_bank, // Bank used by datapath
    output logic irq, // Level interrupt request
    output logic [GML_PEV_W-1:0] parallel_event_vector // Live event vector
);

    // ---------------------------------------------------------------
    // Window geometry
    // ---------------------------------------------------------------
    localparam int WIN = INTERP ? GML_WIN_INTERP :
        (IN_WIDTH == 8) ? GML_WIN_8 : (IN_WIDTH == 10) ? GML_WIN_10 : GML_WIN_12;
    localparam int LIMIT = NUM_TABLES * WIN;
    localparam logic [31:0] LIMIT_W = 32'(LIMIT);

    // ---------------------------------------------------------------
    // Register access decode
    // ---------------------------------------------------------------
    logic wr_en;
    logic wr_status;
    logic wr_error;
    logic wr_irq_en;
    logic wr_upd;
    logic wr_tbl;
    logic [15:0] tbl_idx;
    logic [15:0] tbl_val;
    logic idx_ok;
    logic tbl_we;
    logic [GML_TBL_AW:0] tbl_waddr;
    logic [GML_TBL_AW:0] tbl_raddr;

    // Strobe decode, gated when the bus is not built
    always_comb begin
        wr_en = HAS_BUS && reg_wr;
        wr_status = wr_en && (reg_addr == GML_OFS_STATUS);
        wr_error = wr_en && (reg_addr == GML_OFS_ERROR);
        wr_irq_en = wr_en && (reg_addr == GML_OFS_IRQ_EN);
        wr_upd = wr_en && (reg_addr == GML_OFS_TBL_UPD);
        wr_tbl = wr_en && (reg_addr == GML_OFS_ADDR_DATA);
    end

    always_comb begin
        tbl_idx = reg_wdata[GML_IDX_MSB:GML_IDX_LSB];
        tbl_val = reg_wdata[GML_VAL_MSB:GML_VAL_LSB];
    end

    always_comb begin
        idx_ok = ({16'h0000, tbl_idx} < LIMIT_W);
        tbl_we = wr_tbl && idx_ok;
    end

    // ---------------------------------------------------------------
    // Bank select
    // ---------------------------------------------------------------
    logic bank_q;
    logic bank_d;

    always_comb begin
        bank_d = bank_q;
        if (DOUBLE_BUF && wr_upd && reg_wdata[GML_UPD_SWAP]) begin
            bank_d = ~bank_q;
        end
    end

    // Bank register
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            bank_q <= GML_RST_BANK;
        end else begin
            bank_q <= bank_d;
        end
    end

    always_comb begin
        tbl_waddr = {DOUBLE_BUF && !bank_q, tbl_idx[GML_TBL_AW-1:0]};
        tbl_raddr = {DOUBLE_BUF && bank_q, lut_rd_addr};
        active_bank = bank_q;
    end

    gml_table_mem #(
        .AW(GML_TBL_AW + 1),
        .DW(GML_TBL_DW)
    ) u_mem (
        .mclk(mclk),
        .resetn(resetn),
        .we(tbl_we),
        .waddr(tbl_waddr),
        .wdata(tbl_val),
        .raddr(tbl_raddr),
        .rdata_q(lut_rd_data)
    );

    // ---------------------------------------------------------------
    // Status, error and enable registers
    // ---------------------------------------------------------------
    logic [31:0] status_q;
    logic [31:0] status_d;
    logic [31:0] error_q;
    logic [31:0] error_d;
    logic [31:0] irq_en_q;
    logic [31:0] irq_en_d;
    logic [31:0] st_set;
    logic [31:0] er_set;
    logic any_err;

    always_comb begin
        any_err = line_end_early | line_end_late | frame_start_early | frame_start_late;
        st_set = '0;
        st_set[GML_ST_START] = frame_start;
        st_set[GML_ST_DONE] = frame_done;
        st_set[GML_ST_SERR] = any_err;
        er_set = '0;
        er_set[GML_ER_LE_EARLY] = line_end_early;
        er_set[GML_ER_LE_LATE] = line_end_late;
        er_set[GML_ER_FS_EARLY] = frame_start_early;
        er_set[GML_ER_FS_LATE] = frame_start_late;
    end

    // sticky flags, write one clears, set wins
    always_comb begin
        status_d = (status_q & ~(wr_status ? reg_wdata : 32'h0000_0000)) | st_set;
        error_d = (error_q & ~(wr_error ? reg_wdata : 32'h0000_0000)) | er_set;
        irq_en_d = wr_irq_en ? reg_wdata : irq_en_q;
    end

    // Flag and enable registers
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            status_q <= GML_RST_REG;
            error_q <= GML_RST_REG;
            irq_en_q <= GML_RST_REG;
        end else begin
            status_q <= status_d;
            error_q <= error_d;
            irq_en_q <= irq_en_d;
        end
    end

    always_comb begin
        irq = HAS_BUS && (|(status_q & irq_en_q));
    end

    // ---------------------------------------------------------------
    // Parallel event vector
    // ---------------------------------------------------------------
    logic [GML_PEV_W-1:0] pev_q;
    logic [GML_PEV_W-1:0] pev_d;

    always_comb begin
        pev_d = '0;
        if (EVENT_PORT) begin
            pev_d[GML_PEV_START] = frame_start;
            pev_d[GML_PEV_DONE] = frame_done;
            pev_d[GML_PEV_SERR] = any_err;
            pev_d[GML_PEV_LE_EARLY] = line_end_early;
            pev_d[GML_PEV_LE_LATE] = line_end_late;
            pev_d[GML_PEV_FS_EARLY] = frame_start_early;
            pev_d[GML_PEV_FS_LATE] = frame_start_late;
        end
    end

    // Vector register
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pev_q <= '0;
        end else begin
            pev_q <= pev_d;
        end
    end

    assign parallel_event_vector = pev_q;

    // ---------------------------------------------------------------
    // Read port
    // ---------------------------------------------------------------
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;

    // Read mux, unmapped and write-only read zero
    always_comb begin
        rvalid_d = HAS_BUS && reg_rd;
        rdata_d = '0;
        if (rvalid_d) begin
            case (reg_addr)
                GML_OFS_STATUS: rdata_d = status_q;
                GML_OFS_ERROR: rdata_d = error_q;
                GML_OFS_IRQ_EN: rdata_d = irq_en_q;
                default: rdata_d = '0;
            endcase
        end
    end

    // Read registers
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= '0;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    // valid write stores value
    a_table_write: assert property (@(posedge mclk) disable iff (!resetn)
        (HAS_BUS && reg_wr && reg_addr == GML_OFS_ADDR_DATA && reg_wdata[31:16] < 16'(LIMIT))
        |-> tbl_we ##1 (u_mem.mem[$past(tbl_waddr)] == $past(reg_wdata[GML_VAL_MSB:GML_VAL_LSB])))
        else $error("valid table write not stored");

    a_index_field: assert property (@(posedge mclk) disable iff (!resetn)
        tbl_we |-> (tbl_waddr[GML_TBL_AW-1:0] == reg_wdata[GML_IDX_LSB+GML_TBL_AW-1:GML_IDX_LSB]))
        else $error("table index field wrong");

    a_bad_index: assert property (@(posedge mclk) disable iff (!resetn)
        (reg_wr && reg_addr == GML_OFS_ADDR_DATA && reg_wdata[31:16] >= 16'(LIMIT)) |-> !tbl_we)
        else $error("out of window write accepted");

    a_flag_hold: assert property (@(posedge mclk) disable iff (!resetn)
        (status_q[GML_ST_DONE] && !(wr_status && reg_wdata[GML_ST_DONE]))
        |=> status_q[GML_ST_DONE] [*1])
        else $error("status flag dropped");

    a_flag_clear: assert property (@(posedge mclk) disable iff (!resetn)
        (HAS_BUS && reg_wr && reg_addr == GML_OFS_STATUS && reg_wdata[GML_ST_START] && !frame_start)
        |=> !status_q[GML_ST_START])
        else $error("status flag not cleared");

    a_error_sum: assert property (@(posedge mclk) disable iff (!resetn)
        (line_end_late || frame_start_early) |=> (status_q[GML_ST_SERR] && |error_q[3:0]))
        else $error("error event not recorded");

    a_irq_mask: assert property (@(posedge mclk) disable iff (!resetn)
        (frame_start && irq_en_q[GML_ST_START] && !wr_irq_en) |=> (irq == HAS_BUS))
        else $error("enabled flag did not raise irq");

    a_irq_quiet: assert property (@(posedge mclk) disable iff (!resetn)
        ((status_q & irq_en_q) == 32'h0000_0000) |-> !irq)
        else $error("irq without enabled flag");

    a_vec_live: assert property (@(posedge mclk) disable iff (!resetn)
        !frame_done |=> !parallel_event_vector[GML_PEV_DONE])
        else $error("vector bit held after event");

    a_bank_swap: assert property (@(posedge mclk) disable iff (!resetn)
        (DOUBLE_BUF && wr_upd && reg_wdata[GML_UPD_SWAP]) |=> (active_bank != $past(active_bank)))
        else $error("bank did not swap");

endmodule : gml_lut_irq

// ==== tb/gml_host_model.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Host and edge-capturing interrupt controller
// ---------------------------------------------------------------
module gml_host_model
    import gml_pkg::*;
(
    input wire logic mclk, // Core clock
    input wire logic resetn, // Async reset, active low
    output logic reg_wr, // Write strobe
    output logic reg_rd, // Read strobe
    output logic [15:0] reg_addr, // Byte offset
    output logic [31:0] reg_wdata, // Write data
    input wire logic [31:0] reg_rdata, // Read data
    input wire logic reg_rvalid, // Read answer
    input wire logic [GML_PEV_W-1:0] pev, // Live event vector
    output logic [GML_PEV_W-1:0] pev_seen // Captured rising edges
);
    logic [GML_PEV_W-1:0] pev_q;

    // Idle bus at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 16'hFFFF;
        reg_wdata = 32'hFFFFFFFF;
    end

    // index and value in one word
    // strobe held for one cycle, then address and data inverted
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(negedge mclk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge mclk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr

    // Read answer taken one cycle after the strobe
    task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic v);
        @(negedge mclk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge mclk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
        v = reg_rvalid;
    endtask : rd

    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pev_q <= '0;
            pev_seen <= '0;
        end else begin
            pev_q <= pev;
            pev_seen <= pev_seen | (pev & ~pev_q);
        end
    end
endmodule : gml_host_model

// ==== tb/gml_lut_irq_tb.sv ====
`timescale 1ns/1ps
module gml_lut_irq_tb;
    import gml_pkg::*;
    logic mclk, resetn, reg_wr, reg_rd, reg_rvalid, active_bank, irq;
    logic [15:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [5:0] ev;
    logic [GML_TBL_AW-1:0] lut_rd_addr;
    logic [GML_TBL_DW-1:0] lut_rd_data;
    logic [GML_PEV_W-1:0] pev, pev_seen;
    int failures, tests_run;

    gml_lut_irq #(.IN_WIDTH(8), .NUM_TABLES(2), .HAS_BUS(1'b1),
        .EVENT_PORT(1'b1)) dut (
        .mclk(mclk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .frame_start(ev[0]), .frame_done(ev[1]),
        .line_end_early(ev[2]), .line_end_late(ev[3]), .frame_start_early(ev[4]),
        .frame_start_late(ev[5]), .lut_rd_addr(lut_rd_addr),
        .lut_rd_data(lut_rd_data), .active_bank(active_bank), .irq(irq),
        .parallel_event_vector(pev));

    gml_host_model host (.mclk(mclk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .pev(pev), .pev_seen(pev_seen));

    // Clock generation
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Compare and count
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : check

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] e, input string n);
        logic [31:0] d;
        logic v;
        host.rd(a, d, v);
        check({n, " valid"}, 32'(v), 32'h1);
        check(n, d, e);
    endtask : rd_chk

    task automatic lut_chk(input logic [13:0] a, input logic [15:0] e);
        @(negedge mclk);
        lut_rd_addr = a;
        @(negedge mclk);
        check("lut_rd_data", 32'(lut_rd_data), 32'(e));
    endtask : lut_chk

    task automatic conclude;
        if (failures == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude

    // Outputs after reset and the write-only or unmapped places
    task automatic t_reset;
        check("irq", 32'(irq), 32'h0);
        check("pev", 32'(pev), 32'h0);
        check("active_bank", 32'(active_bank), 32'h0);
        rd_chk(GML_OFS_ADDR_DATA, 32'h0, "addr_data");
        rd_chk(16'h0040, 32'h0, "unmapped");
        rd_chk(GML_OFS_STATUS, 32'h0, "status");
    endtask : t_reset

    // Entries at both window edges of table 1, and entry 5 and the upper edge of table 0
    task automatic t_table;
        host.wr(GML_OFS_ADDR_DATA, 32'h00050ABC);
        host.wr(GML_OFS_ADDR_DATA, 32'h00FF00AA);
        host.wr(GML_OFS_ADDR_DATA, 32'h01000F0F);
        host.wr(GML_OFS_ADDR_DATA, 32'h01FF1234);
        lut_chk(14'h0005, 16'h0ABC);
        lut_chk(14'h00FF, 16'h00AA);
        lut_chk(14'h0100, 16'h0F0F);
        lut_chk(14'h01FF, 16'h1234);
    endtask : t_table

    // Writes outside the windows or to other offsets leave entry 0 alone
    task automatic t_outside;
        host.wr(GML_OFS_ADDR_DATA, 32'h00005A5A);
        host.wr(GML_OFS_ADDR_DATA, 32'h0200FFFF);
        host.wr(GML_OFS_ADDR_DATA, 32'h4000EEEE);
        host.wr(16'h0108, 32'h00001111);
        host.wr(GML_OFS_TBL_UPD, 32'h00000001);
        lut_chk(14'h0000, 16'h5A5A);
        check("bank fixed", 32'(active_bank), 32'h0);
    endtask : t_outside

    // Each event source under a given enable mask
    task automatic t_events(input logic [31:0] en);
        logic [31:0] st, er, pv;
        host.wr(GML_OFS_IRQ_EN, en);
        for (int i = 0; i < 6; i++) begin
            st = (i < 2) ? (32'h1 << i) : 32'h00010000;
            er = (i < 2) ? 32'h0 : (32'h1 << (i - 2));
            pv = (i < 2) ? (32'h1 << i) : ((32'h1 << (i + 3)) | 32'h10);
            @(negedge mclk);
            ev[i] = 1'b1;
            @(negedge mclk);
            ev = '0;
            check("pev on", 32'(pev), pv);
            check("irq on", 32'(irq), 32'((st & en) != 0));
            @(negedge mclk);
            check("pev off", 32'(pev), 32'h0);
            rd_chk(GML_OFS_STATUS, st, "status held");
            rd_chk(GML_OFS_ERROR, er, "error held");
            check("irq held", 32'(irq), 32'((st & en) != 0));
            host.wr(GML_OFS_ERROR, er);
            host.wr(GML_OFS_STATUS, st);
            rd_chk(GML_OFS_STATUS, 32'h0, "status clr");
            rd_chk(GML_OFS_ERROR, 32'h0, "error clr");
            check("irq clr", 32'(irq), 32'h0);
        end
    endtask : t_events

    // Watchdog
    initial begin
        #50000;
        failures++;
        conclude();
    end

    // Main sequence
    initial begin
        failures = 0;
        tests_run = 0;
        resetn = 1'b0;
        ev = '0;
        lut_rd_addr = '0;
        repeat (2) @(negedge mclk);
        resetn = 1'b1;
        t_reset();
        t_table();
        t_outside();
        t_events(32'h0);
        t_events(32'h00010003);
        t_events(32'h00010002);
        check("pev_seen", 32'(pev_seen), 32'h000001F3);
        conclude();
    end
endmodule : gml_lut_irq_tb
